// ---- rtl/csph_spi_port.sv ----
// memory-mapped spi host port: axi4-lite registers, chip selects, sense inputs
// Contract
// - write sends byte, read returns last received
// - control bit 6 picks write or read trigger
// - read trigger mode: transfer register read starts transfer when idle
// - control bit 7 set disables the port
// - clock chip shares lines, own select only
// - bits 4,1 select card, none, flash, clock
// - control bits 4 and 1 both low assert card select
// - control bit 0 swaps boot rom for external
// - rom block and flash update change unlocked
// - status register is read only
// - status bits report write protect, card presence
// - status reports cartridge config and game lines
// - status bit 0 shows transfer busy
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module csph_spi_port
   import csph_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [CSPH_AW-1:0]  s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [CSPH_AW-1:0]  s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output var  logic                spi_sclk,
   output var  logic                spi_mosi,
   input  wire logic                spi_miso,
   output var  logic                card_cs_n,
   output var  logic                flash_cs_n,
   output var  logic                rtc_cs_n,
   input  wire logic                card_present_n,
   input  wire logic                card_wp,
   input  wire logic                cart_rom_config_line,
   input  wire logic                game_line,
   output var  logic                boot_rom_off,
   output var  logic                ext_rom_block,
   output var  logic                flash_update_mode,
   output var  logic                irq
);
   typedef struct packed {
      logic [4:0] sy1;
      logic [4:0] sy2;
      logic [7:0] ctl;
      logic [7:0] tx;
      logic       start;
      logic       unlock;
      logic [1:0] ext;
      logic [1:0] irq_st;
      logic [1:0] irq_msk;
      logic       irq;
      logic       cd_prev;
      logic [2:0] cs_n;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } csph_top_s;
   csph_top_s r, n;

   csph_xfer_if xf ();

   logic       wr_fire;
   logic       rd_fire;
   logic       busy_eff;
   logic       can_start;
   logic [7:0] status;
   logic [1:0] sel;
   logic [1:0] ev;
   logic [1:0] irq_clr;

   // sync bit order: miso, presence, protect, config line, game line
   localparam int SY_MISO = 4;
   localparam int SY_CD   = 3;
   localparam int SY_WP   = 2;
   localparam int SY_EX   = 1;
   localparam int SY_GAME = 0;

   // one write and one read at a time; address and data are taken together
   assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
   assign rd_fire       = s_axi_arvalid && !r.rvalid;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready  = wr_fire;
   assign s_axi_arready = !r.rvalid;

   // a start still in flight counts as busy, so a back-to-back request cannot double fire
   assign busy_eff  = xf.busy || r.start;
   assign can_start = !busy_eff && !r.ctl[CSPH_CTL_OFF];
   assign sel       = {r.ctl[CSPH_CTL_SELHI], r.ctl[CSPH_CTL_SELLO]};

   // live status view; flash jumper bit 5 and bits above read zero
   always_comb
   begin
      status                = 8'h00;
      status[CSPH_ST_WP]    = r.sy2[SY_WP];
      status[CSPH_ST_CD]    = r.sy2[SY_CD];
      status[CSPH_ST_CART_ROM_CONFIG_LINE] = r.sy2[SY_EX];
      status[CSPH_ST_GAME]  = r.sy2[SY_GAME];
      status[CSPH_ST_BUSY]  = busy_eff;
   end

   // interrupt events: transfer finished, card inserted or pulled
   assign ev[CSPH_IRQ_DONE]  = xf.done;
   assign ev[CSPH_IRQ_CDCHG] = r.sy2[SY_CD] ^ r.cd_prev;

   always_comb
   begin
      n         = r;
      irq_clr   = 2'h0;
      n.sy1     = {spi_miso, card_present_n, card_wp, cart_rom_config_line, game_line};
      n.sy2     = r.sy1;
      n.cd_prev = r.sy2[SY_CD];
      n.start   = 1'b0;
      if (r.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (r.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      // register writes; only byte lane 0 carries data
      if (wr_fire)
      begin
         n.bvalid = 1'b1;
         n.bresp  = CSPH_RESP_OK;
         if (s_axi_awaddr == CSPH_A_XFER)
         begin
            if (s_axi_wstrb[0])
            begin
               n.tx = s_axi_wdata[7:0];
               if (!r.ctl[CSPH_CTL_TRIG] && can_start)
                  n.start = 1'b1;
            end
         end
         else if (s_axi_awaddr == CSPH_A_CTL)
         begin
            if (s_axi_wstrb[0])
               n.ctl = s_axi_wdata[7:0]; // bit 3 kept but unused
         end
         else if (s_axi_awaddr == CSPH_A_STAT || s_axi_awaddr == CSPH_A_IRQST)
         begin
            n.bresp = CSPH_RESP_OK; // writes dropped, flags untouched
         end
         else if (s_axi_awaddr == CSPH_A_IRQMSK)
         begin
            if (s_axi_wstrb[0])
               n.irq_msk = s_axi_wdata[1:0];
         end
         else if (s_axi_awaddr == CSPH_A_EXT)
         begin
            if (s_axi_wstrb[0])
            begin
               // lock is judged on the old value, so unlocking takes a write of its own
               if (r.unlock)
                  n.ext = s_axi_wdata[1:0];
               n.unlock = s_axi_wdata[CSPH_EXT_UNLOCK];
            end
         end
         else
         begin
            n.bresp = CSPH_RESP_ERR;
         end
      end
      // register reads; data captured at the accepting edge
      if (rd_fire)
      begin
         n.rvalid = 1'b1;
         n.rresp  = CSPH_RESP_OK;
         n.rdata  = 8'h00;
         if (s_axi_araddr == CSPH_A_XFER)
         begin
            n.rdata = xf.rx; // previous byte even when this read starts the next
            if (r.ctl[CSPH_CTL_TRIG] && can_start && !n.start)
               n.start = 1'b1;
         end
         else if (s_axi_araddr == CSPH_A_CTL)
            n.rdata = r.ctl;
         else if (s_axi_araddr == CSPH_A_STAT)
            n.rdata = status;
         else if (s_axi_araddr == CSPH_A_IRQST)
         begin
            n.rdata = {6'h00, r.irq_st};
            irq_clr = r.irq_st;
         end
         else if (s_axi_araddr == CSPH_A_IRQMSK)
            n.rdata = {6'h00, r.irq_msk};
         else if (s_axi_araddr == CSPH_A_EXT)
            n.rdata = {r.unlock, 5'h00, r.ext};
         else
            n.rresp = CSPH_RESP_ERR;
      end
      // set wins over the read clear
      n.irq_st = (r.irq_st & ~irq_clr) | ev;
      n.irq    = |(n.irq_st & n.irq_msk);
      // chip selects: one shared bus, targets told apart only by select
      n.cs_n = 3'h7;
      if (!n.ctl[CSPH_CTL_OFF])
      begin
         if ({n.ctl[CSPH_CTL_SELHI], n.ctl[CSPH_CTL_SELLO]} == CSPH_SEL_CARD)
            n.cs_n[0] = 1'b0; // bits 4 and 1 both low select the card
         else if ({n.ctl[CSPH_CTL_SELHI], n.ctl[CSPH_CTL_SELLO]} == CSPH_SEL_FLASH)
            n.cs_n[1] = 1'b0;
         else if ({n.ctl[CSPH_CTL_SELHI], n.ctl[CSPH_CTL_SELLO]} == CSPH_SEL_RTC)
            n.cs_n[2] = 1'b0; // slow rate is software's job here
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= '{sy1: 5'h1F, sy2: 5'h1F, ctl: CSPH_CTL_RST, tx: 8'hFF, start: 1'b0, unlock: 1'b0,
                ext: 2'h0, irq_st: 2'h0, irq_msk: 2'h0, irq: 1'b0, cd_prev: 1'b1, cs_n: 3'h7,
                bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rresp: 2'h0, rdata: 8'h00};
      end
      else
      begin
         r <= n;
      end
   end

   // engine hand-off
   assign xf.start  = r.start;
   assign xf.tx     = r.tx;
   assign xf.fast   = r.ctl[CSPH_CTL_FAST];
   assign xf.miso_s = r.sy2[SY_MISO];

   csph_spi_engine #(
      .SLOW_HALF (CSPH_SLOW_HALF),
      .FAST_HALF (CSPH_FAST_HALF)
   ) u_engine (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .xf       (xf.eng),
      .spi_sclk (spi_sclk),
      .spi_mosi (spi_mosi)
   );

   // register-driven outputs
   assign s_axi_bvalid      = r.bvalid;
   assign s_axi_bresp       = r.bresp;
   assign s_axi_rvalid      = r.rvalid;
   assign s_axi_rresp       = r.rresp;
   assign s_axi_rdata       = {24'h000000, r.rdata};
   assign card_cs_n         = r.cs_n[0];
   assign flash_cs_n        = r.cs_n[1];
   assign rtc_cs_n          = r.cs_n[2];
   assign boot_rom_off      = r.ctl[CSPH_CTL_BOOT];
   assign ext_rom_block     = r.ext[CSPH_EXT_ROMBLK];
   assign flash_update_mode = r.ext[CSPH_EXT_FLASH];
   assign irq               = r.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_write_start: assert property (wr_fire && s_axi_awaddr == CSPH_A_XFER && s_axi_wstrb[0]
      && !r.ctl[CSPH_CTL_TRIG] && can_start |=> r.start ##1 xf.busy)
      else $error("write did not start transfer");
   chk_read_start: assert property (rd_fire && s_axi_araddr == CSPH_A_XFER && !wr_fire
      && r.ctl[CSPH_CTL_TRIG] && can_start |=> r.start && s_axi_rdata[7:0] == $past(xf.rx))
      else $error("read did not start transfer");
   chk_no_wrong_trig: assert property (r.start |-> $past(wr_fire) != $past(r.ctl[CSPH_CTL_TRIG])
      || $past(rd_fire))
      else $error("transfer started by wrong access");
   chk_off_no_start: assert property (r.start |-> !$past(r.ctl[CSPH_CTL_OFF]))
      else $error("disabled port started transfer");
   // selects and control register load at the same edge, so both are compared in the same cycle
   chk_rtc_select: assert property (!rtc_cs_n |-> card_cs_n && flash_cs_n && sel == CSPH_SEL_RTC
      && !r.ctl[CSPH_CTL_OFF])
      else $error("clock chip select wrong");
   chk_card_select: assert property (!card_cs_n |-> !r.ctl[CSPH_CTL_SELLO]
      && !r.ctl[CSPH_CTL_SELHI])
      else $error("card select wrong");
   chk_boot_write: assert property (wr_fire && s_axi_awaddr == CSPH_A_CTL && s_axi_wstrb[0]
      |=> boot_rom_off == $past(s_axi_wdata[0]))
      else $error("boot rom bit not taken");
   chk_locked_ext: assert property (wr_fire && s_axi_awaddr == CSPH_A_EXT && !r.unlock
      |=> $stable(ext_rom_block) && $stable(flash_update_mode))
      else $error("locked bits changed");
   chk_status_ro: assert property (wr_fire && s_axi_awaddr == CSPH_A_STAT
      |=> $stable(r.ctl) && $stable(r.tx) && !r.start)
      else $error("status write had effect");
   chk_status_read: assert property (rd_fire && s_axi_araddr == CSPH_A_STAT |=> s_axi_rdata[0] == $past(busy_eff)
      && s_axi_rdata[3] == $past(r.sy2[SY_CD]) && s_axi_rdata[4] == $past(r.sy2[SY_WP]))
      else $error("status read wrong");
   chk_sense_lines: assert property (rd_fire && s_axi_araddr == CSPH_A_STAT |=> s_axi_rdata[2]
      == $past(r.sy2[SY_EX]) && s_axi_rdata[1] == $past(r.sy2[SY_GAME]))
      else $error("sense lines wrong");
   cov_write_xfer: cover property (wr_fire && s_axi_awaddr == CSPH_A_XFER ##1 r.start);
   cov_read_xfer:  cover property (rd_fire && s_axi_araddr == CSPH_A_XFER ##1 r.start);
   cov_irq:        cover property ($rose(irq));
endmodule // csph_spi_port
`default_nettype wire

// ---- inc/csph_pkg.sv ----
// constants shared by the spi host port and its shift engine
`default_nettype none
package csph_pkg;
   // register indices; byte address on the bus is four times the index
   localparam int          CSPH_IDX_XFER   = 32'h0000DF10;
   localparam int          CSPH_IDX_CTL    = 32'h0000DF11;
   localparam int          CSPH_IDX_STAT   = 32'h0000DF12;
   localparam int          CSPH_IDX_IRQST  = 32'h0000DF13;
   localparam int          CSPH_IDX_IRQMSK = 32'h0000DF14;
   localparam int          CSPH_IDX_EXT    = 32'h0000DF15;
   localparam int          CSPH_AW         = 20;
   localparam logic [19:0] CSPH_A_XFER     = 20'(CSPH_IDX_XFER * 4);
   localparam logic [19:0] CSPH_A_CTL      = 20'(CSPH_IDX_CTL * 4);
   localparam logic [19:0] CSPH_A_STAT     = 20'(CSPH_IDX_STAT * 4);
   localparam logic [19:0] CSPH_A_IRQST    = 20'(CSPH_IDX_IRQST * 4);
   localparam logic [19:0] CSPH_A_IRQMSK   = 20'(CSPH_IDX_IRQMSK * 4);
   localparam logic [19:0] CSPH_A_EXT      = 20'(CSPH_IDX_EXT * 4);
   // control register fields
   localparam int          CSPH_CTL_OFF    = 7;
   localparam int          CSPH_CTL_TRIG   = 6;
   localparam int          CSPH_CTL_SELHI  = 4;
   localparam int          CSPH_CTL_FAST   = 2;
   localparam int          CSPH_CTL_SELLO  = 1;
   localparam int          CSPH_CTL_BOOT   = 0;
   localparam logic [7:0]  CSPH_CTL_RST    = 8'h02;
   // status register fields
   localparam int          CSPH_ST_WP      = 4;
   localparam int          CSPH_ST_CD      = 3;
   localparam int          CSPH_ST_CART_ROM_CONFIG_LINE   = 2;
   localparam int          CSPH_ST_GAME    = 1;
   localparam int          CSPH_ST_BUSY    = 0;
   // extension register fields
   localparam int          CSPH_EXT_UNLOCK = 7;
   localparam int          CSPH_EXT_FLASH  = 1;
   localparam int          CSPH_EXT_ROMBLK = 0;
   // interrupt bits
   localparam int          CSPH_IRQ_DONE   = 0;
   localparam int          CSPH_IRQ_CDCHG  = 1;
   // target select codes {ctl[4], ctl[1]}
   localparam logic [1:0]  CSPH_SEL_CARD   = 2'h0;
   localparam logic [1:0]  CSPH_SEL_FLASH  = 2'h2;
   localparam logic [1:0]  CSPH_SEL_RTC    = 2'h3;
   // axi responses
   localparam logic [1:0]  CSPH_RESP_OK    = 2'h0;
   localparam logic [1:0]  CSPH_RESP_ERR   = 2'h2;
   // serial clock half periods; rounded up so the rate never exceeds the nominal one
   localparam int          CSPH_CLK_PS     = 10000;
   localparam int          CSPH_SLOW_HALF_PS = 2000000;
   localparam int          CSPH_FAST_HALF_PS = 62500;
   localparam int          CSPH_SLOW_HALF  = (CSPH_SLOW_HALF_PS + CSPH_CLK_PS - 1) / CSPH_CLK_PS;
   localparam int          CSPH_FAST_HALF  = (CSPH_FAST_HALF_PS + CSPH_CLK_PS - 1) / CSPH_CLK_PS;
endpackage
`default_nettype wire

// ---- inc/csph_xfer_if.sv ----
// byte transfer handshake between register block and shift engine
`timescale 1ns/100ps
`default_nettype none
interface csph_xfer_if;
   logic       start;
   logic [7:0] tx;
   logic       fast;
   logic       miso_s;
   logic       busy;
   logic       done;
   logic [7:0] rx;
   modport port (output start, output tx, output fast, output miso_s, input busy, input done, input rx);
   modport eng  (input start, input tx, input fast, input miso_s, output busy, output done, output rx);
endinterface
`default_nettype wire

// ---- rtl/csph_spi_engine.sv ----
// eight bit msb-first spi shift engine, mode 0, two clock rates
`timescale 1ns/100ps
`default_nettype none
module csph_spi_engine
   import csph_pkg::*;
#(
   parameter int SLOW_HALF = CSPH_SLOW_HALF,
   parameter int FAST_HALF = CSPH_FAST_HALF
)(
   input  wire logic  aclk,
   input  wire logic  aresetn,
   csph_xfer_if.eng   xf,
   output var  logic  spi_sclk,
   output var  logic  spi_mosi
);
   typedef enum logic [1:0] {ENG_IDLE = 2'h0, ENG_LOW = 2'h1, ENG_HIGH = 2'h3} csph_eng_e;
   typedef struct packed {
      csph_eng_e  st;
      logic [7:0] div;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic       samp;
      logic       sclk;
      logic       fast;
      logic       done;
      logic [7:0] rx;
   } csph_eng_s;
   csph_eng_s r, n;
   logic [7:0] half_m1;

   generate
      if (SLOW_HALF < 1 || SLOW_HALF > 256 || FAST_HALF < 1 || FAST_HALF > 256)
      begin : g_bad_half
         $error("half period must be 1 to 256 cycles");
      end
   endgenerate

   // latched rate picks the half period so a mid-byte rate change cannot tear a bit
   assign half_m1 = r.fast ? 8'(FAST_HALF - 1) : 8'(SLOW_HALF - 1);

   always_comb
   begin
      n = r;
      n.done = 1'b0;
      case (r.st)
         ENG_IDLE:
         begin
            if (xf.start)
            begin
               n.sh   = xf.tx;
               n.bitn = 3'h0;
               n.div  = 8'h00;
               n.fast = xf.fast;
               n.st   = ENG_LOW;
            end
         end
         ENG_LOW:
         begin
            n.div = r.div + 8'h01;
            if (r.div == half_m1)
            begin
               n.div  = 8'h00;
               n.sclk = 1'b1;
               n.samp = xf.miso_s;
               n.st   = ENG_HIGH;
            end
         end
         ENG_HIGH:
         begin
            n.div = r.div + 8'h01;
            if (r.div == half_m1)
            begin
               n.div  = 8'h00;
               n.sclk = 1'b0;
               n.sh   = {r.sh[6:0], r.samp}; // msb first
               if (r.bitn == 3'h7)
               begin
                  n.rx   = {r.sh[6:0], r.samp}; // captured on the eighth bit
                  n.done = 1'b1;
                  n.st   = ENG_IDLE;
               end
               else
               begin
                  n.bitn = r.bitn + 3'h1;
                  n.st   = ENG_LOW;
               end
            end
         end
         default:
         begin
            n.st = ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= '{st: ENG_IDLE, div: 8'h00, bitn: 3'h0, sh: 8'hFF, samp: 1'b0, sclk: 1'b0,
                fast: 1'b0, done: 1'b0, rx: 8'hFF};
      end
      else
      begin
         r <= n;
      end
   end

   assign spi_sclk = r.sclk;
   assign spi_mosi = r.sh[7];
   assign xf.busy  = (r.st != ENG_IDLE);
   assign xf.done  = r.done;
   assign xf.rx    = r.rx;

   // helper: count serial clock rises since the start
   logic [3:0] rises_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rises_r <= 4'h0;
      else if (xf.start && r.st == ENG_IDLE)
         rises_r <= 4'h0;
      else if (n.sclk && !r.sclk)
         rises_r <= rises_r + 4'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_eight_rises: assert property (r.done |-> rises_r == 4'h8)
      else $error("transfer did not clock eight bits");
   chk_fast_phase: assert property ($rose(r.sclk) && r.fast |-> r.sclk[*7] ##1 !r.sclk)
      else $error("fast high phase wrong length");
   chk_slow_phase: assert property ($rose(r.sclk) && !r.fast |-> ##199 r.sclk ##1 !r.sclk)
      else $error("slow high phase wrong length");
   cov_fast_xfer: cover property (r.done && r.fast);
   cov_slow_xfer: cover property (r.done && !r.fast);
endmodule // csph_spi_engine
`default_nettype wire

// ---- test/csph_spi_slave.sv ----
// spi target model shared by card, flash and clock chip: mode 0, msb first
`timescale 1ns/100ps
`default_nettype none
module csph_spi_slave
(
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       cs_n,
   input  wire logic [7:0] reply,
   output var  logic       miso,
   output var  logic [7:0] got
);
   logic [7:0] sh;
   logic [2:0] n;
   // first bit ready before the first rise
   always @(negedge cs_n)
   begin
      sh = reply;
      n = 3'h0;
      miso = reply[7];
   end
   // sample on rise, msb first
   always @(posedge sclk)
      if (!cs_n)
         got = {got[6:0], mosi};
   // shift on fall; the eighth fall loads the queued reply
   always @(negedge sclk)
      if (!cs_n)
      begin
         n = n + 3'h1;
         sh = (n == 3'h0) ? reply : {sh[6:0], 1'b0};
         miso = sh[7];
      end
   // released line floats: invert so stale data never matches
   always @(posedge cs_n)
      miso = ~miso;
endmodule // csph_spi_slave
`default_nettype wire

// ---- test/csph_spi_port_bench.sv ----
// self-checking bench for the spi host port
`timescale 1ns/100ps
`default_nettype none
module csph_spi_port_bench;
   import csph_pkg::*;
   logic [CSPH_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [2:0]         s_axi_awprot, s_axi_arprot;
   logic [1:0]         s_axi_bresp, s_axi_rresp, r;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aclk, aresetn, irq;
   logic               spi_sclk, spi_mosi, spi_miso, card_cs_n, flash_cs_n, rtc_cs_n, card_present_n, card_wp;
   logic               cart_rom_config_line, game_line, boot_rom_off, ext_rom_block, flash_update_mode;
   logic [7:0]         reply, got, d, v;
   int                 n_fail, tests_run;
   csph_spi_port u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .card_cs_n(card_cs_n), .flash_cs_n(flash_cs_n), .rtc_cs_n(rtc_cs_n),
      .card_present_n(card_present_n), .card_wp(card_wp), .cart_rom_config_line(cart_rom_config_line),
      .game_line(game_line), .boot_rom_off(boot_rom_off), .ext_rom_block(ext_rom_block),
      .flash_update_mode(flash_update_mode), .irq(irq));
   csph_spi_slave u_far (.sclk(spi_sclk), .mosi(spi_mosi), .cs_n(card_cs_n & flash_cs_n & rtc_cs_n),
                         .reply(reply), .miso(spi_miso), .got(got));
   always #5 aclk = ~aclk;
   // one axi4-lite transfer; ready and answers are looked at mid-cycle, taken at the next rise
   task automatic bus(input logic wr, input logic [19:0] a, input logic [7:0] x);
      int   n;
      logic ok;
      n = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr} <= {a, a};
      s_axi_wdata <= {24'h0, x};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      do
      begin
         @(negedge aclk);
         ok = wr ? s_axi_awready : s_axi_arready;
         @(posedge aclk);
      end while (ok !== 1'b1 && ++n < 100);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
      do
      begin
         @(negedge aclk);
         ok = wr ? s_axi_bvalid : s_axi_rvalid;
         d = s_axi_rdata[7:0];
         r = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
      end while (ok !== 1'b1 && ++n < 100);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      if (n >= 100)
      begin
         n_fail++;
         $display("Error at %0t: bus handshake timed out", $time);
      end
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // software waits on the busy flag before touching the byte again
   task automatic wait_idle;
      int k;
      k = 0;
      do bus(1'b0, CSPH_A_STAT, 8'h00); while (d[CSPH_ST_BUSY] !== 1'b0 && ++k < 2000);
      chk({7'h0, d[0]}, 8'h00);
   endtask
   // fast card transfer on write, with done interrupt
   task automatic t_fast;
      bus(1'b0, CSPH_A_IRQST, 8'h00);
      bus(1'b1, CSPH_A_IRQMSK, 8'h01);
      chk({7'h0, irq}, 8'h00);
      reply = 8'h3C;
      bus(1'b1, CSPH_A_CTL, 8'h04);
      bus(1'b1, CSPH_A_XFER, 8'hA5);
      reply = 8'hC3; // queued for the following byte
      wait_idle();
      chk({7'h0, irq}, 8'h01);
      bus(1'b0, CSPH_A_XFER, 8'h00);
      chk(d, 8'h3C);
      chk(got, 8'hA5);
      chk({5'h0, card_cs_n, flash_cs_n, rtc_cs_n}, 8'h03);
      bus(1'b0, CSPH_A_IRQST, 8'h00);
      chk({7'h0, d[CSPH_IRQ_DONE]}, 8'h01);
      bus(1'b0, CSPH_A_CTL, 8'h00);
      chk({7'h0, irq}, 8'h00);
   endtask
   // read trigger: returns the old byte and starts a new transfer
   task automatic t_readtrig;
      bus(1'b1, CSPH_A_CTL, 8'h44);
      bus(1'b0, CSPH_A_XFER, 8'h00);
      chk(d, 8'h3C);
      wait_idle();
      chk(got, 8'hA5);
      bus(1'b0, CSPH_A_XFER, 8'h00);
      chk(d, 8'hC3);
      wait_idle();
   endtask
   // every select code, boot rom bit riding along
   task automatic t_sel;
      for (int s = 0; s < 4; s++)
      begin
         v = {3'h0, s[1], 2'h0, s[0], s[1]};
         bus(1'b1, CSPH_A_CTL, v);
         bus(1'b0, CSPH_A_CTL, 8'h00);
         chk(d, v);
         chk({5'h0, card_cs_n, flash_cs_n, rtc_cs_n}, {5'h0, s != 0, s != 2, s != 3});
         chk({7'h0, boot_rom_off}, {7'h0, s[1]});
      end
   endtask
   // disabled port selects nothing and starts nothing
   task automatic t_off;
      bus(1'b1, CSPH_A_CTL, 8'h80);
      bus(1'b1, CSPH_A_XFER, 8'h11);
      bus(1'b0, CSPH_A_STAT, 8'h00);
      chk({4'h0, card_cs_n, flash_cs_n, rtc_cs_n, d[0]}, 8'h0E);
   endtask
   // clock chip only at the slow rate
   task automatic t_slow;
      reply = 8'h5A;
      bus(1'b1, CSPH_A_CTL, 8'h12);
      bus(1'b1, CSPH_A_XFER, 8'h96);
      bus(1'b0, CSPH_A_STAT, 8'h00);
      chk({7'h0, d[0]}, 8'h01);
      wait_idle();
      bus(1'b0, CSPH_A_XFER, 8'h00);
      chk(d, 8'h5A);
      chk(got, 8'h96);
      chk({7'h0, rtc_cs_n}, 8'h00);
   endtask
   // read-only sense bits, locked extension bits, unmapped address
   task automatic t_misc;
      card_wp <= 1'b1;
      cart_rom_config_line <= 1'b1;
      bus(1'b1, CSPH_A_STAT, 8'hFF);
      chk({6'h0, r}, {6'h0, CSPH_RESP_OK});
      bus(1'b0, CSPH_A_STAT, 8'h00);
      chk(d, 8'h14);
      // pull the card and flip both sense lines; the lock writes below give the synchronisers time
      {card_present_n, cart_rom_config_line, game_line} <= 3'h5;
      bus(1'b1, CSPH_A_EXT, 8'h03);
      chk({6'h0, flash_update_mode, ext_rom_block}, 8'h00);
      bus(1'b1, CSPH_A_EXT, 8'h80);
      bus(1'b1, CSPH_A_EXT, 8'h83);
      bus(1'b0, CSPH_A_EXT, 8'h00);
      chk({6'h0, flash_update_mode, ext_rom_block}, 8'h03);
      bus(1'b0, CSPH_A_STAT, 8'h00);
      chk(d, 8'h1A);
      bus(1'b0, CSPH_A_IRQST, 8'h00);
      chk({7'h0, d[CSPH_IRQ_CDCHG]}, 8'h01);
      bus(1'b0, 20'h00000, 8'h00);
      chk({6'h0, r}, {6'h0, CSPH_RESP_ERR});
      bus(1'b1, 20'h00000, 8'h00);
      chk({6'h0, r}, {6'h0, CSPH_RESP_ERR});
   endtask
   task automatic conclude;
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
      {card_present_n, card_wp, cart_rom_config_line, game_line} = 4'h0;
      {s_axi_wstrb, reply} = {4'hF, 8'h00};
      {n_fail, tests_run} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, CSPH_A_CTL, 8'h00);
      chk(d, CSPH_CTL_RST);
      t_fast();
      t_readtrig();
      t_sel();
      t_off();
      t_slow();
      t_misc();
      conclude();
   end
   // watchdog well beyond the expected run
   initial
   begin
      #900000;
      $display("Error at %0t: watchdog expired", $time);
      n_fail++;
      conclude();
   end
endmodule // csph_spi_port_bench
`default_nettype wire
